// >>> design/usfc_pkg.sv
/*
 * usfc_pkg: offsets, field positions, reset values and codes of the
 * serial transceiver frame configuration registers.
 * Assumes byte-wide registers on a plain 4-bit address port.
 */
package usfc_pkg;
	// ==========================================================
	// register offsets
	localparam logic [3:0] USFC_OFS_RXCTL   = 4'h6;
	localparam logic [3:0] USFC_OFS_FRAME   = 4'h7;
	localparam logic [3:0] USFC_OFS_BAUD_LO = 4'h8;
	localparam logic [3:0] USFC_OFS_BAUD_HI = 4'h9;
	localparam logic [3:0] USFC_OFS_WIN     = 4'ha;
	localparam logic [3:0] USFC_OFS_DBG     = 4'hb;
	localparam logic [3:0] USFC_OFS_EV      = 4'hc;
	localparam logic [3:0] USFC_OFS_PULSE   = 4'hd;
	// ==========================================================
	// reset values
	localparam logic [7:0] USFC_RST_FRAME = 8'h03;
	localparam logic [7:0] USFC_RST_SPI   = 8'h00;
	localparam logic [7:0] USFC_RST_ZERO  = 8'h00;
	// ==========================================================
	// field positions
	localparam int USFC_COMM_LSB   = 6;
	localparam int USFC_PAR_LSB    = 4;
	localparam int USFC_SB_BIT     = 3;
	localparam int USFC_DORD_BIT   = 2;
	localparam int USFC_CPHA_BIT   = 1;
	localparam int USFC_WIN_LSB    = 6;
	localparam int USFC_RXSEL_LSB  = 1;
	localparam int USFC_MULTI_BIT  = 0;
	localparam logic [7:0] USFC_SPI_MASK = 8'hc6;
	// ==========================================================
	// codes
	typedef enum logic [1:0] {
		USFC_CM_ASYNC, USFC_CM_SYNC, USFC_CM_IRDA, USFC_CM_SPI
	} usfc_comm_e;
	typedef enum logic [1:0] {
		USFC_PAR_NONE, USFC_PAR_RSVD, USFC_PAR_EVEN, USFC_PAR_ODD
	} usfc_par_e;
	typedef enum logic [1:0] {
		USFC_RX_NORMAL, USFC_RX_CLK2X, USFC_RX_GEN_AUTO, USFC_RX_LIN_AUTO
	} usfc_rxsel_e;
	typedef enum logic [1:0] {
		USFC_PL_3_16, USFC_PL_FIXED, USFC_PL_PASS
	} usfc_pulse_e;
	localparam logic [2:0] USFC_CH_8BIT  = 3'h3;
	localparam logic [2:0] USFC_CH_9LOW  = 3'h6;
	localparam logic [2:0] USFC_CH_9HIGH = 3'h7;
	localparam logic [3:0] USFC_CH_BASE  = 4'h5;
	localparam logic [3:0] USFC_BITS_9   = 4'h9;
	localparam logic [7:0] USFC_PULSE_316  = 8'h00;
	localparam logic [7:0] USFC_PULSE_PASS = 8'hff;
	localparam logic [5:0] USFC_SAMPLES_PER_BIT = 6'h10;
	localparam logic [5:0] USFC_PAIR_NOMINAL =
		6'(2 * USFC_SAMPLES_PER_BIT);
	localparam logic [5:0] USFC_TOL_W0 = 6'h6;
	localparam logic [5:0] USFC_TOL_W1 = 6'h5;
	localparam logic [5:0] USFC_TOL_W2 = 6'h7;
	localparam logic [5:0] USFC_TOL_W3 = 6'h8;
	localparam int USFC_FIFO_DEPTH = 8;
	localparam int USFC_EV_WIDTH   = 8;
endpackage

// >>> design/usfc_regs.sv
/*
 * usfc_regs: configuration register set of a serial transceiver and an
 * event FIFO on the receiver event path; usfc_fifo is its buffer.
 * Assumes a register master that keeps strobes one cycle long and
 * never both at once, and shift engines that read the decoded outputs.
 */
// Function
// - multiproc bit 1 enables multiprocessor addressing, 0 disables it.
// - two-bit comm mode: async, sync, infrared, SPI host.
// - comm mode 3 swaps frame register to SPI host layout.
// - parity field: 0 none, 2 even, 3 odd, 1 reserved.
// - stop select gives one or two stop bits; receiver ignores it.
// - one shared char size; codes 0-3 give 5-8 bits, 4-5 reserved.
// - size 6 nine bits low byte first, 7 high byte first.
// - SPI bit order: 0 MSB first, 1 LSB first, both directions.
// - SPI phase: 0 sample leading edge, 1 trailing edge.
// - 16-bit baud divisor as low byte at base, high at base+1.
// - any baud write updates the prescaler at once.
// - window code 0..3 gives 32 +-6, 5, 7, 8 samples.
// - 16 samples per bit, so 32 nominal per bit pair.
// - debug-run 0 halts and drops events in break; 1 keeps running.
// - event input enable routes event channel into receiver path.
// - pulse length 0 gives 3/16, 1-fe clocks, ff pass-through.
// - window applies only with receiver mode LIN auto-baud.
`timescale 1ns/1ps

// ==============================================================
// event buffer
module usfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        full;
		logic                        empty;
	} usfc_fifo_st_s;
	usfc_fifo_st_s st_q, st_d;
	logic push, pop;

	always_comb
	begin
		st_d = st_q;
		push = in_valid && !st_q.full;
		pop  = out_ready && !st_q.empty;
		if (push)
		begin
			st_d.mem[st_q.wp] = in_data;
			st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
		end
		if (pop)
			st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		st_d.full  = (st_d.cnt == (AW+1)'(DEPTH));
		st_d.empty = (st_d.cnt == '0);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_q <= '{mem: '0, wp: '0, rp: '0, cnt: '0,
				full: 1'b0, empty: 1'b1};
		else
			st_q <= st_d;
	end

	assign in_ready  = !st_q.full;
	assign out_valid = !st_q.empty;
	assign out_data  = st_q.mem[st_q.rp];
endmodule // usfc_fifo

// ==============================================================
// register set
module usfc_regs #(
	parameter int EV_WIDTH   = usfc_pkg::USFC_EV_WIDTH,
	parameter int FIFO_DEPTH = usfc_pkg::USFC_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                rst,
	// register port
	input  wire logic [3:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	// frame format
	output usfc_pkg::usfc_comm_e     comm_mode_sel,
	output logic                     multiproc_addr_mode,
	output usfc_pkg::usfc_par_e      parity_sel,
	output logic                     parity_en,
	output logic                     parity_odd,
	output logic                     stop_bit_count_sel,
	output logic [3:0]               data_bits,
	output logic                     nine_bit_low_first,
	output logic                     nine_bit_high_first,
	// spi host
	output logic                     spi_host_mode,
	output logic                     spi_bit_order,
	output logic                     spi_sample_phase,
	// baud and auto-baud
	output logic [15:0]              baud_div,
	output logic                     baud_load,
	output usfc_pkg::usfc_rxsel_e    receiver_mode_sel,
	output logic                     lin_autobaud_mode,
	output logic [5:0]               samples_per_bit,
	output logic [5:0]               win_min,
	output logic [5:0]               win_max,
	// debug and infrared
	input  wire logic                dbg_break,
	output logic                     xcvr_halt,
	output logic                     infrared_mode,
	output usfc_pkg::usfc_pulse_e    tx_pulse_mode,
	output logic [7:0]               tx_pulse_len,
	// event channel in
	input  wire logic                ev_valid,
	input  wire logic [EV_WIDTH-1:0] ev_data,
	output logic                     ev_ready,
	// event channel to receiver
	output logic                     rx_ev_valid,
	output logic [EV_WIDTH-1:0]      rx_ev_data,
	input  wire logic                rx_ev_ready
);
	import usfc_pkg::*;

	typedef struct packed {
		logic [7:0]   frame;
		logic [2:0]   rxctl;
		logic [15:0]  baud;
		logic [1:0]   win_code;
		logic         run_dbg;
		logic         ev_en;
		logic [7:0]   pulse;
		logic [7:0]   rdata;
		logic         baud_load;
		usfc_comm_e   comm;
		usfc_par_e    par;
		logic         par_en;
		logic         par_odd;
		logic         two_stop;
		logic [3:0]   dbits;
		logic         nine_lo;
		logic         nine_hi;
		logic         spi;
		logic         lsb_first;
		logic         trail;
		logic         multi;
		usfc_rxsel_e  rxsel;
		logic         lin;
		logic [5:0]   wmin;
		logic [5:0]   wmax;
		logic         halt;
		logic         ir;
		usfc_pulse_e  pulse_sel;
		logic [7:0]   plen;
	} usfc_regs_st_s;

	usfc_regs_st_s st_q, st_d;
	logic          halt_now;
	logic          fifo_in_valid;
	logic          fifo_in_ready;

	// ==========================================================
	// helpers
	function automatic logic [5:0] usfc_tol(input logic [1:0] code);
		case (code)
			2'h0:    usfc_tol = USFC_TOL_W0;
			2'h1:    usfc_tol = USFC_TOL_W1;
			2'h2:    usfc_tol = USFC_TOL_W2;
			default: usfc_tol = USFC_TOL_W3;
		endcase
	endfunction

	function automatic logic [7:0] usfc_read(input usfc_regs_st_s s,
		input logic [3:0] a);
		case (a)
			USFC_OFS_RXCTL:   usfc_read = {5'h00, s.rxctl};
			USFC_OFS_FRAME:   usfc_read = s.frame;
			USFC_OFS_BAUD_LO: usfc_read = s.baud[7:0];
			USFC_OFS_BAUD_HI: usfc_read = s.baud[15:8];
			USFC_OFS_WIN:     usfc_read = {s.win_code, 6'h00};
			USFC_OFS_DBG:     usfc_read = {7'h00, s.run_dbg};
			USFC_OFS_EV:      usfc_read = {7'h00, s.ev_en};
			USFC_OFS_PULSE:   usfc_read = s.pulse;
			default:          usfc_read = USFC_RST_ZERO;
		endcase
	endfunction

	// ==========================================================
	// next state
	always_comb
	begin
		st_d = st_q;
		st_d.baud_load = 1'b0;
		st_d.rdata = reg_rd ? usfc_read(st_q, reg_addr) : USFC_RST_ZERO;
		if (reg_wr)
		begin
			case (reg_addr)
				USFC_OFS_RXCTL:
					st_d.rxctl = reg_wdata[2:0];
				USFC_OFS_FRAME:
					// spi layout keeps only its own bits
					if (reg_wdata[USFC_COMM_LSB +: 2] == USFC_CM_SPI)
						st_d.frame = reg_wdata & USFC_SPI_MASK;
					else
						st_d.frame = reg_wdata;
				USFC_OFS_BAUD_LO:
				begin
					st_d.baud[7:0] = reg_wdata;
					st_d.baud_load = 1'b1;
				end
				USFC_OFS_BAUD_HI:
				begin
					st_d.baud[15:8] = reg_wdata;
					st_d.baud_load = 1'b1;
				end
				USFC_OFS_WIN:
					st_d.win_code = reg_wdata[USFC_WIN_LSB +: 2];
				USFC_OFS_DBG:
					st_d.run_dbg = reg_wdata[0];
				USFC_OFS_EV:
					st_d.ev_en = reg_wdata[0];
				USFC_OFS_PULSE:
					st_d.pulse = reg_wdata;
				default:
					st_d.rxctl = st_q.rxctl;
			endcase
		end

		// decode from the value being written, so outputs follow the
		// register in the same cycle the register itself updates
		st_d.comm = usfc_comm_e'(st_d.frame[USFC_COMM_LSB +: 2]);
		st_d.spi = (st_d.comm == USFC_CM_SPI);
		st_d.ir  = (st_d.comm == USFC_CM_IRDA);
		if (st_d.spi)
		begin
			// normal fields do not exist in this layout
			st_d.par       = USFC_PAR_NONE;
			st_d.two_stop  = 1'b0;
			st_d.dbits     = USFC_CH_BASE + {1'b0, USFC_CH_8BIT};
			st_d.nine_lo   = 1'b0;
			st_d.nine_hi   = 1'b0;
			st_d.lsb_first = st_d.frame[USFC_DORD_BIT];
			st_d.trail     = st_d.frame[USFC_CPHA_BIT];
		end
		else
		begin
			st_d.par = usfc_par_e'(st_d.frame[USFC_PAR_LSB +: 2]);
			st_d.two_stop  = st_d.frame[USFC_SB_BIT];
			st_d.nine_lo   = (st_d.frame[2:0] == USFC_CH_9LOW);
			st_d.nine_hi   = (st_d.frame[2:0] == USFC_CH_9HIGH);
			// reserved sizes 4 and 5 report zero bits
			if (st_d.nine_lo || st_d.nine_hi)
				st_d.dbits = USFC_BITS_9;
			else if (st_d.frame[2])
				st_d.dbits = 4'h0;
			else
				st_d.dbits = USFC_CH_BASE + {1'b0, st_d.frame[2:0]};
			st_d.lsb_first = 1'b0;
			st_d.trail     = 1'b0;
		end
		// reserved parity code generates no parity
		st_d.par_en  = (st_d.par == USFC_PAR_EVEN) ||
			(st_d.par == USFC_PAR_ODD);
		st_d.par_odd = (st_d.par == USFC_PAR_ODD);
		st_d.multi = st_d.rxctl[USFC_MULTI_BIT];
		st_d.rxsel = usfc_rxsel_e'(st_d.rxctl[USFC_RXSEL_LSB +: 2]);
		st_d.lin = (st_d.rxsel == USFC_RX_LIN_AUTO);
		// window open only in LIN auto-baud
		st_d.wmin = st_d.lin ? USFC_PAIR_NOMINAL - usfc_tol(st_d.win_code)
			: USFC_PAIR_NOMINAL;
		st_d.wmax = st_d.lin ? USFC_PAIR_NOMINAL + usfc_tol(st_d.win_code)
			: USFC_PAIR_NOMINAL;
		st_d.halt = dbg_break && !st_d.run_dbg;
		if (st_d.pulse == USFC_PULSE_316)
			st_d.pulse_sel = USFC_PL_3_16;
		else if (st_d.pulse == USFC_PULSE_PASS)
			st_d.pulse_sel = USFC_PL_PASS;
		else
			st_d.pulse_sel = USFC_PL_FIXED;
		st_d.plen = st_d.pulse;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.frame <= USFC_RST_FRAME;
			st_q.dbits <= USFC_CH_BASE + {1'b0, USFC_CH_8BIT};
			st_q.wmin  <= USFC_PAIR_NOMINAL;
			st_q.wmax  <= USFC_PAIR_NOMINAL;
		end
		else
			st_q <= st_d;
	end

	// ==========================================================
	// event path
	// halted or disabled path drops events rather than stalling the
	// event channel, so a stopped core never blocks other users
	assign halt_now = dbg_break && !st_q.run_dbg;
	assign fifo_in_valid = ev_valid && st_q.ev_en && !halt_now;

	usfc_fifo #(
		.WIDTH (EV_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_ev_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (fifo_in_valid),
		.in_data   (ev_data),
		.in_ready  (fifo_in_ready),
		.out_valid (rx_ev_valid),
		.out_data  (rx_ev_data),
		.out_ready (rx_ev_ready && !halt_now)
	);

	// dropped events are accepted, buffered ones honour back-pressure
	assign ev_ready = fifo_in_ready || !st_q.ev_en || halt_now;

	// ==========================================================
	// outputs
	assign reg_rdata           = st_q.rdata;
	assign comm_mode_sel       = st_q.comm;
	assign multiproc_addr_mode = st_q.multi;
	assign parity_sel          = st_q.par;
	assign parity_en           = st_q.par_en;
	assign parity_odd          = st_q.par_odd;
	assign stop_bit_count_sel  = st_q.two_stop;
	assign data_bits           = st_q.dbits;
	assign nine_bit_low_first  = st_q.nine_lo;
	assign nine_bit_high_first = st_q.nine_hi;
	assign spi_host_mode       = st_q.spi;
	// order change mid-transfer is software's to avoid
	assign spi_bit_order       = st_q.lsb_first;
	assign spi_sample_phase    = st_q.trail;
	assign baud_div            = st_q.baud;
	assign baud_load           = st_q.baud_load;
	assign receiver_mode_sel   = st_q.rxsel;
	assign lin_autobaud_mode   = st_q.lin;
	assign samples_per_bit     = USFC_SAMPLES_PER_BIT;
	assign win_min             = st_q.wmin;
	assign win_max             = st_q.wmax;
	assign xcvr_halt           = st_q.halt;
	assign infrared_mode       = st_q.ir;
	assign tx_pulse_mode       = st_q.pulse_sel;
	assign tx_pulse_len        = st_q.plen;
endmodule // usfc_regs

// >>> testbench/test_usart_frame_config_regs.sv
/*
 * test_usart_frame_config_regs: self-checking bench of usfc_regs.
 * Assumes usfc_rx_model as receiver and usfc_asserts bound.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end

module test_usart_frame_config_regs;
	import usfc_pkg::*;
	// ======================================================
	// signals
	logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic dbg_break = 1'b0, ev_valid = 1'b0, stall = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, ev_data = 8'h00;
	logic [7:0] reg_rdata, rx_ev_data, tx_pulse_len;
	logic [3:0] data_bits;
	logic [15:0] baud_div;
	logic [5:0] samples_per_bit, win_min, win_max;
	logic multiproc_addr_mode, parity_en, parity_odd, stop_bit_count_sel;
	logic nine_bit_low_first, nine_bit_high_first, spi_host_mode;
	logic spi_bit_order, spi_sample_phase, baud_load, lin_autobaud_mode;
	logic xcvr_halt, infrared_mode, ev_ready, rx_ev_valid, rx_ev_ready;
	usfc_comm_e comm_mode_sel;
	usfc_par_e parity_sel;
	usfc_rxsel_e receiver_mode_sel;
	usfc_pulse_e tx_pulse_mode;
	int err_count = 0, checked = 0, cycles = 0;

	usfc_regs DUT (.*);
	usfc_rx_model RX (.*);

	always #2.5 mclk = ~mclk;
	// ======================================================
	// bus tasks
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task automatic push(input logic [7:0] d);
		@(posedge mclk);
		ev_valid <= 1'b1;
		ev_data <= d;
		do @(negedge mclk); while (ev_ready !== 1'b1);
		@(posedge mclk);
		ev_valid <= 1'b0;
	endtask
	// ======================================================
	// scenarios
	task t_reset;
		rd(USFC_OFS_FRAME, USFC_RST_FRAME);
		for (int a = 8; a < 14; a++)
			rd(4'(a), 8'h00);
		`CHK(data_bits, 4'h8)
		$display("reset test done");
	endtask
	task t_frame;
		logic [7:0] v;
		logic [3:0] nb;
		for (int i = 0; i < 8; i++)
		begin
			v = {2'(i % 3), 2'(i), i[0], 3'(i)};
			nb = (i < 4) ? 4'(5 + i) : (i > 5) ? 4'h9 : 4'h0;
			wr(USFC_OFS_FRAME, v);
			#1 `CHK(comm_mode_sel, usfc_comm_e'(i % 3))
			`CHK(infrared_mode, i % 3 == 2)
			`CHK({parity_en, parity_odd}, {v[5], v[5] & v[4]})
			`CHK(parity_sel, usfc_par_e'(2'(i)))
			`CHK(stop_bit_count_sel, v[3])
			`CHK(data_bits, nb)
			`CHK({nine_bit_high_first, nine_bit_low_first}, {i == 7, i == 6})
			rd(USFC_OFS_FRAME, v);
		end
		$display("frame test done");
	endtask
	task t_spi;
		// order changes only with no event traffic
		wr(USFC_OFS_FRAME, 8'hff);
		#1 `CHK({spi_host_mode, spi_bit_order, spi_sample_phase}, 3'h7)
		`CHK(data_bits, 4'h8)
		rd(USFC_OFS_FRAME, 8'hc6);
		wr(USFC_OFS_FRAME, 8'hc0);
		#1 `CHK({spi_bit_order, spi_sample_phase}, 2'h0)
		wr(USFC_OFS_FRAME, 8'hc4);
		#1 `CHK({spi_bit_order, spi_sample_phase}, 2'h2)
		wr(USFC_OFS_FRAME, 8'hc2);
		#1 `CHK({spi_bit_order, spi_sample_phase}, 2'h1)
		wr(USFC_OFS_FRAME, 8'h02);
		#1 `CHK({spi_host_mode, data_bits}, 5'h07)
		$display("spi test done");
	endtask
	task t_baud;
		wr(USFC_OFS_BAUD_LO, 8'h34);
		#1 `CHK(baud_load, 1'b1)
		`CHK(baud_div, 16'h0034)
		wr(USFC_OFS_BAUD_HI, 8'h12);
		#1 `CHK(baud_div, 16'h1234)
		rd(USFC_OFS_BAUD_HI, 8'h12);
		`CHK(baud_load, 1'b0)
		$display("baud test done");
	endtask
	task t_abw;
		logic [5:0] tol [4] = '{6'h6, 6'h5, 6'h7, 6'h8};
		wr(USFC_OFS_RXCTL, 8'h07);
		for (int w = 0; w < 4; w++)
		begin
			wr(USFC_OFS_WIN, {2'(w), 6'h3f});
			#1 `CHK(win_min, 6'h20 - tol[w])
			`CHK(win_max, 6'h20 + tol[w])
		end
		`CHK({lin_autobaud_mode, multiproc_addr_mode}, 2'h3)
		`CHK(samples_per_bit, 6'h10)
		`CHK(receiver_mode_sel, USFC_RX_LIN_AUTO)
		rd(USFC_OFS_WIN, 8'hc0);
		wr(USFC_OFS_RXCTL, 8'h04);
		#1 `CHK({lin_autobaud_mode, multiproc_addr_mode, win_max}, 8'h20)
		rd(USFC_OFS_RXCTL, 8'h04);
		$display("window test done");
	endtask
	task t_tx_pulse_len;
		logic [7:0] pl [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
		for (int k = 0; k < 4; k++)
		begin
			wr(USFC_OFS_PULSE, pl[k]);
			#1 `CHK(tx_pulse_mode, usfc_pulse_e'((k + 1) / 2))
			`CHK(tx_pulse_len, pl[k])
		end
		wr(4'he, 8'hff);
		rd(4'he, 8'h00);
		rd(4'h0, 8'h00);
		$display("pulse test done");
	endtask
	task t_events;
		push(8'h11);
		repeat (3) @(posedge mclk);
		#1 `CHK(rx_ev_valid, 1'b0)
		wr(USFC_OFS_EV, 8'h01);
		stall <= 1'b1;
		for (int n = 0; n < 8; n++)
			push(8'(8'ha0 + n));
		@(negedge mclk) `CHK(ev_ready, 1'b0)
		@(posedge mclk) stall <= 1'b0;
		repeat (12) @(posedge mclk);
		#1 `CHK(rx_ev_valid, 1'b0)
		for (int n = 0; n < 8; n++)
			`CHK(RX.q[n], 8'(8'ha0 + n))
		// halted and not running in debug: event dropped
		dbg_break <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 `CHK(xcvr_halt, 1'b1)
		push(8'h55);
		wr(USFC_OFS_DBG, 8'hff);
		rd(USFC_OFS_DBG, 8'h01);
		push(8'h66);
		repeat (4) @(posedge mclk);
		#1 `CHK(xcvr_halt, 1'b0)
		`CHK(RX.q.size(), 9)
		`CHK(RX.q[8], 8'h66)
		$display("event test done");
	endtask
	// ======================================================
	// run control
	task complete_run;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_count++;
			complete_run();
		end
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_frame();
		t_spi();
		t_baud();
		t_abw();
		t_tx_pulse_len();
		t_events();
		complete_run();
	end
endmodule // test_usart_frame_config_regs

// >>> testbench/usfc_asserts.sv
/*
 * usfc_asserts: port checks of usfc_regs.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps

// ==========================================================
// checker
module usfc_asserts
	import usfc_pkg::*;
(
	// clock and reset
	input wire logic                   mclk,
	input wire logic                   rst,
	// register port
	input wire logic [3:0]             reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	// decoded outputs and debug break input
	input wire usfc_pkg::usfc_comm_e   comm_mode_sel,
	input wire logic                   spi_host_mode,
	input wire usfc_pkg::usfc_par_e    parity_sel,
	input wire logic                   parity_en,
	input wire logic                   parity_odd,
	input wire logic [15:0]            baud_div,
	input wire logic                   baud_load,
	input wire usfc_pkg::usfc_rxsel_e  receiver_mode_sel,
	input wire logic                   lin_autobaud_mode,
	input wire logic [5:0]             win_min,
	input wire logic [5:0]             win_max,
	input wire logic                   dbg_break,
	input wire logic                   xcvr_halt
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_baud_wr;
		reg_wr && (reg_addr == USFC_OFS_BAUD_LO ||
			reg_addr == USFC_OFS_BAUD_HI);
	endsequence
	property p_baud_load;
		s_baud_wr |=> baud_load;
	endproperty
	a_baud_load: assert property (p_baud_load)
		else $error("baud load missing");
	property p_baud_lo;
		reg_wr && reg_addr == USFC_OFS_BAUD_LO
			|=> baud_div[7:0] == $past(reg_wdata);
	endproperty
	a_baud_lo: assert property (p_baud_lo)
		else $error("baud low byte wrong");
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read");
	property p_spi;
		spi_host_mode == (comm_mode_sel == USFC_CM_SPI);
	endproperty
	a_spi: assert property (p_spi)
		else $error("spi layout mismatch");
	property p_par;
		parity_en == parity_sel[1] &&
			parity_odd == (parity_sel == USFC_PAR_ODD);
	endproperty
	a_par: assert property (p_par)
		else $error("parity decode wrong");
	property p_win;
		7'(win_min) + 7'(win_max) == 7'h40 &&
			(lin_autobaud_mode || win_min == 6'h20);
	endproperty
	a_win: assert property (p_win)
		else $error("window not centred");
	property p_lin;
		lin_autobaud_mode == (receiver_mode_sel == USFC_RX_LIN_AUTO);
	endproperty
	a_lin: assert property (p_lin)
		else $error("lin mode decode wrong");
	property p_halt;
		xcvr_halt |-> $past(dbg_break);
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt without break");
endmodule // usfc_asserts

bind usfc_regs usfc_asserts u_chk (.*);

// >>> testbench/usfc_rx_model.sv
/*
 * usfc_rx_model: receiver draining the event channel into a queue.
 * Assumes the bench sets stall to hold ready low.
 */
`timescale 1ns/1ps

// ==========================================================
// receiver
module usfc_rx_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// event channel
	input  wire logic       rx_ev_valid,
	input  wire logic [7:0] rx_ev_data,
	output logic            rx_ev_ready,
	// bench control
	input  wire logic       stall
);
	logic [7:0] q [$];
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			rx_ev_ready <= 1'b0;
		else
		begin
			if (rx_ev_valid && rx_ev_ready)
				q.push_back(rx_ev_data);
			rx_ev_ready <= !stall;
		end
	end
endmodule // usfc_rx_model
